//--- design/gis_defs.svh
// offsets, bit positions and reset values for the outgoing byte and event status block
`ifndef GIS_DEFS_SVH
`define GIS_DEFS_SVH

// address width and register offsets on the host port
`define GIS_ADDR_W        12
`define GIS_OFF_DATA      12'h111
`define GIS_OFF_STATUS    12'h113
`define GIS_OFF_PASSED    12'h11B

// event positions in status and mask
`define GIS_B_CPT         7
`define GIS_B_APT         6
`define GIS_B_DET         5
`define GIS_B_END         4
`define GIS_B_DEC         3
`define GIS_B_ERR         2
`define GIS_B_DO          1
`define GIS_B_DI          0

// zero byte for reset and idle, and the event count
`define GIS_BYTE_ZERO     8'h00
`define GIS_EVENT_N       8

`endif

//--- design/gis_pkg.sv
// shared types for the outgoing byte and event status block
package gis_pkg;

  typedef logic [7:0] gis_byte_t;

  // acceptor handshake hold, one-hot
  typedef enum logic [2:0] {
    GIS_RUN      = 3'b001,
    GIS_HOLD_CPT = 3'b010,
    GIS_HOLD_APT = 3'b100
  } gis_hold_t;

endpackage : gis_pkg

//--- design/gis_rise.sv
// rising edge detector for a vector of interface state levels
`timescale 1ns/1ps
`default_nettype none
module gis_rise #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         srst,
  // levels in, one-cycle pulses out
  input  wire logic [W-1:0] lvl,
  output logic      [W-1:0] rise
);
  import gis_pkg::*;

  // refuse an empty vector at elaboration
  if (W < 1)
  begin : g_w_check
    $error("gis_rise: W must be at least 1");
  end

  typedef struct packed {
    logic [W-1:0] prev;
  } gis_rise_st_t;

  gis_rise_st_t st;
  gis_rise_st_t next_st;

  // remember last level
  always_comb
  begin
    next_st      = st;
    next_st.prev = lvl;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      st <= '0;
    else
      st <= next_st;
  end

  assign rise = lvl & ~st.prev;

endmodule : gis_rise
`default_nettype wire

//--- design/gis_flag_bank.sv
// sticky event flags with clear-on-read and deferred set during a read
`timescale 1ns/1ps
`default_nettype none
module gis_flag_bank #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         srst,
  // event sets, hardware clears, read clear
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  input  wire logic         rd_clr,
  // flag state
  output logic      [W-1:0] status
);
  import gis_pkg::*;

  // refuse an empty bank at elaboration
  if (W < 1)
  begin : g_w_check
    $error("gis_flag_bank: W must be at least 1");
  end

  typedef struct packed {
    logic [W-1:0] flag;
    logic [W-1:0] pend;
  } gis_flag_st_t;

  gis_flag_st_t st;
  gis_flag_st_t next_st;
  logic [W-1:0] next_flag;
  logic [W-1:0] next_pend;

  // per bit: a read parks new events so the clear cannot swallow them
  for (genvar i = 0; i < W; i++)
  begin : g_bit
    assign next_flag[i] = rd_clr ? 1'b0
                                 : ((st.flag[i] & ~clr[i]) | set[i] | st.pend[i]);
    assign next_pend[i] = rd_clr & (set[i] | st.pend[i]);
  end

  always_comb
  begin
    next_st      = st;
    next_st.flag = next_flag;
    next_st.pend = next_pend;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      st <= '0;
    else
      st <= next_st;
  end

  assign status = st.flag;

endmodule : gis_flag_bank
`default_nettype wire

//--- design/gis_out_irq.sv
// outgoing byte latch, first event status and mask pair, pass-through holds
`timescale 1ns/1ps
`default_nettype none
`include "gis_defs.svh"

module gis_out_irq (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   srst,
  // host register port
  input  wire logic [`GIS_ADDR_W-1:0] addr,
  input  wire logic                   wr_en,
  input  wire logic                   rd_en,
  input  wire gis_pkg::gis_byte_t     wdata,
  output logic                        [7:0] rdata,
  output logic                        irq,
  // bus data lines and source start
  input  wire gis_pkg::gis_byte_t     dio_in,
  output logic                        [7:0] dio_out,
  output logic                        src_start,
  // interface function states
  input  wire logic                   tacs,
  input  wire logic                   cacs,
  input  wire logic                   sgns,
  input  wire logic                   sdys,
  input  wire logic                   sids,
  input  wire logic                   lacs,
  input  wire logic                   tads,
  input  wire logic                   lads,
  input  wire logic                   tpas,
  input  wire logic                   lpas,
  input  wire logic                   dtas,
  input  wire logic                   dcas,
  input  wire logic                   acds,
  input  wire logic                   dac,
  input  wire logic                   rfd,
  input  wire logic                   eoi,
  // received command class
  input  wire logic                   cmd_ucg,
  input  wire logic                   cmd_acg,
  input  wire logic                   cmd_scg,
  input  wire logic                   cmd_tag,
  input  wire logic                   cmd_lag,
  input  wire logic                   cmd_defined,
  // configuration bits
  input  wire logic                   pass_through_enable,
  input  wire logic                   addr_mode_hi,
  input  wire logic                   addr_mode_lo,
  input  wire logic                   string_end_match_enable,
  input  wire gis_pkg::gis_byte_t     string_end_reg,
  // auxiliary releases
  input  wire logic                   aux_valid,
  input  wire logic                   aux_nonvalid,
  // handshake controls
  output logic                        hold_acds,
  output logic                        hold_dac,
  output logic                        rfd_allow
);
  import gis_pkg::*;

  typedef struct packed {
    gis_byte_t out_byte_reg;
    gis_byte_t din;
    logic      din_full;
    gis_byte_t passed_cmd_reg;
    gis_byte_t irq_mask_one;
    logic      undefined_primary_latch;
    gis_hold_t hold;
    logic      sdys_q;
    gis_byte_t rdata;
    logic      src_start;
    logic      irq;
    logic      rfd_allow;
  } gis_st_t;

  gis_st_t st;
  gis_st_t next_st;

  logic      wr_data;
  logic      wr_mask;
  logic      rd_status;
  logic      rd_data;
  logic      rd_passed;
  logic [3:0] rise;
  logic      acds_rise;
  logic      det_rise;
  logic      dec_rise;
  logic      gen_rise;
  logic      undef_primary;
  logic      cpt_evt;
  logic      apt_evt;
  logic      byte_in;
  logic      end_evt;
  logic      err_evt;
  logic      udp_clr;
  logic [7:0] ev_set;
  logic [7:0] ev_clr;
  logic [7:0] irq_status_one;

  // strobes decoded from the printed offsets
  assign wr_data   = wr_en & (addr == `GIS_OFF_DATA);
  assign wr_mask   = wr_en & (addr == `GIS_OFF_STATUS);
  assign rd_status = rd_en & (addr == `GIS_OFF_STATUS);
  assign rd_data   = rd_en & (addr == `GIS_OFF_DATA);
  assign rd_passed = rd_en & (addr == `GIS_OFF_PASSED);

  // state entries become single-cycle events
  gis_rise #(
    .W (4)
  ) u_rise (
    .clk  (clk),
    .srst (srst),
    .lvl  ({acds, dtas, dcas, tacs & sgns}),
    .rise (rise)
  );

  assign acds_rise = rise[3];
  assign det_rise  = rise[2];
  assign dec_rise  = rise[1];
  assign gen_rise  = rise[0];

  // addressed commands only count while addressed
  assign undef_primary = (cmd_ucg | (cmd_acg & (tads | lads))) & ~cmd_defined;

  // pass-through off: no command pass-through flag, no accept hold
  assign cpt_evt = acds_rise & pass_through_enable
                   & (undef_primary | (st.undefined_primary_latch & cmd_scg));

  assign apt_evt = acds_rise & addr_mode_hi & addr_mode_lo
                   & (tpas | lpas) & cmd_scg;

  assign udp_clr = (acds_rise & (((cmd_ucg | cmd_acg) & cmd_defined)
                   | cmd_tag | cmd_lag)) | ~pass_through_enable;

  // listener data byte acceptance
  assign byte_in = acds_rise & lacs;
  assign end_evt = byte_in & (eoi | (string_end_match_enable
                   & (dio_in == string_end_reg)));

  // talker faults: handshake lines both true, write when idle, delay to idle
  assign err_evt = (tacs & sdys & dac & rfd) | (sids & wr_data)
                   | (st.sdys_q & sids);

  // event sets by position
  always_comb
  begin
    ev_set             = `GIS_BYTE_ZERO;
    ev_set[`GIS_B_CPT] = cpt_evt;
    ev_set[`GIS_B_APT] = apt_evt;
    ev_set[`GIS_B_DET] = det_rise;
    ev_set[`GIS_B_END] = end_evt;
    ev_set[`GIS_B_DEC] = dec_rise;
    ev_set[`GIS_B_ERR] = err_evt;
    ev_set[`GIS_B_DO]  = gen_rise;
    ev_set[`GIS_B_DI]  = byte_in;
  end

  // only data-out has a hardware clear; set still wins over it
  always_comb
  begin
    ev_clr            = `GIS_BYTE_ZERO;
    ev_clr[`GIS_B_DO] = wr_data | ~tacs | ~sgns;
  end

  // flags ignore the mask entirely
  gis_flag_bank #(
    .W (`GIS_EVENT_N)
  ) u_flags (
    .clk    (clk),
    .srst   (srst),
    .set    (ev_set),
    .clr    (ev_clr),
    .rd_clr (rd_status),
    .status (irq_status_one)
  );

  // next state of the register side and handshake holds
  always_comb
  begin
    next_st           = st;
    next_st.src_start = 1'b0;
    next_st.sdys_q    = sdys;
    // outgoing byte only moves on a write, never on incoming reads
    if (wr_data && (tacs || cacs))
    begin
      next_st.out_byte_reg = wdata;
      next_st.src_start    = 1'b1;
    end
    if (wr_mask)
      next_st.irq_mask_one = wdata;
    // incoming byte; removal wins only without a new byte
    if (rd_data)
      next_st.din_full = 1'b0;
    if (byte_in)
    begin
      next_st.din      = dio_in;
      next_st.din_full = 1'b1;
    end
    next_st.rfd_allow = ~next_st.din_full;
    // undefined primary latch, set beats clear
    if (udp_clr)
      next_st.undefined_primary_latch = 1'b0;
    if (acds_rise && pass_through_enable && undef_primary)
      next_st.undefined_primary_latch = 1'b1;
    if (cpt_evt || apt_evt)
      next_st.passed_cmd_reg = dio_in;
    // acceptor hold machine
    case (st.hold)
      GIS_RUN:
      begin
        if (cpt_evt)
          next_st.hold = GIS_HOLD_CPT;
        else if (apt_evt)
          next_st.hold = GIS_HOLD_APT;
      end
      GIS_HOLD_CPT:
      begin
        if (aux_valid)
          next_st.hold = GIS_RUN;
      end
      GIS_HOLD_APT:
      begin
        if (aux_valid || aux_nonvalid)
          next_st.hold = GIS_RUN;
      end
      default:
        next_st.hold = GIS_RUN;
    endcase
    // read data, unmapped reads return zero
    if (rd_status)
      next_st.rdata = irq_status_one;
    else if (rd_data)
      next_st.rdata = st.din;
    else if (rd_passed)
      next_st.rdata = st.passed_cmd_reg;
    else
      next_st.rdata = `GIS_BYTE_ZERO;
    next_st.irq = |(irq_status_one & st.irq_mask_one);
  end

  // one register for all state outside the flag bank and edge detector; mask and byte reset to zero
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st           <= '0;
      st.hold      <= GIS_RUN;
      st.rfd_allow <= 1'b1;
    end
    else
      st <= next_st;
  end

  // outputs straight from flops
  assign rdata     = st.rdata;
  assign irq       = st.irq;
  assign dio_out   = st.out_byte_reg;
  assign src_start = st.src_start;
  assign hold_acds = st.hold[1];
  assign hold_dac  = st.hold[2];
  assign rfd_allow = st.rfd_allow;

  // checks on the block's own outputs and internal state
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_write_go;
    wr_data && (tacs || cacs);
  endsequence

  sequence s_read_with_event;
    rd_status && (ev_set != `GIS_BYTE_ZERO) ##1 !rd_status;
  endsequence

  sequence s_cpt_taken;
    st.hold == GIS_RUN && cpt_evt;
  endsequence

  a_src_start_byte: assert property (
    s_write_go |=> src_start && dio_out == $past(wdata)
                   ##1 (src_start == $past(wr_data && (tacs || cacs))))
    else $error("write did not start source handshake");

  a_outbyte_kept: assert property (
    rd_data && !wr_data |=> $stable(dio_out))
    else $error("incoming read disturbed outgoing byte");

  a_read_clears: assert property (
    rd_status && ev_set == `GIS_BYTE_ZERO && !$past(rd_status)
    |=> irq_status_one == `GIS_BYTE_ZERO)
    else $error("status read did not clear");

  a_deferred_set: assert property (
    s_read_with_event |=> (irq_status_one & $past(ev_set, 2)) == $past(ev_set, 2))
    else $error("event lost to clear on read");

  a_irq_mask_or: assert property (
    ##1 irq == $past(|(irq_status_one & st.irq_mask_one)))
    else $error("interrupt request wrong");

  a_irq_needs_mask: assert property (
    st.irq_mask_one == `GIS_BYTE_ZERO [*2] |-> !irq)
    else $error("request with all enables clear");

  a_cpt_hold_set: assert property (
    s_cpt_taken |=> hold_acds)
    else $error("pass-through did not hold accept");

  a_cpt_hold_wait: assert property (
    hold_acds && !aux_valid |=> hold_acds)
    else $error("accept hold released without valid");

  a_apt_hold: assert property (
    st.hold == GIS_RUN && !cpt_evt && apt_evt |=> hold_dac && !hold_acds)
    else $error("address pass-through did not hold");

  a_cpt_disabled: assert property (
    !pass_through_enable && !hold_acds |=> !hold_acds)
    else $error("undefined command flagged while disabled");

  a_unaddressed: assert property (
    cmd_acg && !cmd_ucg && !tads && !lads && !st.undefined_primary_latch
    |-> !ev_set[`GIS_B_CPT])
    else $error("unaddressed command passed through");

  a_udp_off: assert property (
    !pass_through_enable |=> !st.undefined_primary_latch)
    else $error("latch kept with pass-through off");

  a_err_write: assert property (
    sids && wr_data && !rd_status |=> irq_status_one[`GIS_B_ERR])
    else $error("idle write did not flag error");

  a_do_clear: assert property (
    !tacs && !rd_status && !$past(rd_status) |=> !irq_status_one[`GIS_B_DO])
    else $error("data-out kept after talker ended");

  a_rfd_hold: assert property (
    byte_in || (!rfd_allow && !rd_data) |=> !rfd_allow)
    else $error("ready-for-data not held");

endmodule : gis_out_irq
`default_nettype wire

//--- design/gis_out_irq_note_end.sv
// intentionally empty design unit list terminator
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

//--- sim/gis_bus_peer.sv
// far-side talker model that offers bytes on the bus data lines
`timescale 1ns/1ps
`default_nettype none
module gis_bus_peer (
  // clock and device handshake state
  input  wire logic       clk,
  input  wire logic       rfd_allow,
  input  wire logic       hold,
  // lines seen by the device
  output logic      [7:0] dio_in,
  output logic            eoi,
  output logic            acds,
  // the waits of one put took 40 cycles or more in all
  output logic            stuck
);
  initial
  begin
    dio_in = 8'h5A;
    eoi    = 1'b0;
    acds   = 1'b0;
    stuck  = 1'b0;
  end

  // offer one byte at a falling edge; released lines never show the old byte
  task automatic put(input logic [7:0] b, input logic e);
    int n;
    n = 0;
    while (!rfd_allow && n < 40)
    begin
      @(negedge clk);
      n++;
    end
    dio_in = b;
    eoi    = e;
    acds   = 1'b1;
    repeat (2) @(negedge clk);
    while (hold && n < 80)
    begin
      @(negedge clk);
      n++;
    end
    stuck  = stuck | (n >= 40);
    acds   = 1'b0;
    eoi    = 1'b0;
    dio_in = ~b;
    @(negedge clk);
  endtask : put
endmodule : gis_bus_peer
`default_nettype wire

//--- sim/test_gis_out_irq.sv
// randomised self-checking bench for the outgoing byte and event status block
`timescale 1ns/1ps
`default_nettype none
module test_gis_out_irq;
  import gis_pkg::*;
  // clock, reset, host port
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [11:0] addr;
  logic        wr_en, rd_en, irq, src_start, stuck;
  gis_byte_t   wdata, rdata, dio_in, dio_out, string_end_reg;
  // interface states and controls
  logic tacs, cacs, sgns, sdys, sids, lacs, tads, lads, tpas, lpas, dtas, dcas, dac, rfd, eoi;
  logic acds, hold_acds, hold_dac, rfd_allow, aux_valid, aux_nonvalid;
  logic pass_through_enable, addr_mode_hi, addr_mode_lo, string_end_match_enable;
  logic [5:0]  cls;
  wire logic   cmd_ucg, cmd_acg, cmd_scg, cmd_tag, cmd_lag, cmd_defined;
  int          fail_count = 0;
  int          check_count = 0;
  logic [7:0]  b, m, r1, r2;

  // command class as one field: ucg acg scg tag lag defined
  assign {cmd_ucg, cmd_acg, cmd_scg, cmd_tag, cmd_lag, cmd_defined} = cls;
  always #10 clk = ~clk;

  gis_out_irq i_gis_out_irq (
    .clk, .srst, .addr, .wr_en, .rd_en, .wdata, .rdata, .irq, .dio_in, .dio_out, .src_start,
    .tacs, .cacs, .sgns, .sdys, .sids, .lacs, .tads, .lads, .tpas, .lpas, .dtas, .dcas,
    .acds, .dac, .rfd, .eoi, .cmd_ucg, .cmd_acg, .cmd_scg, .cmd_tag, .cmd_lag, .cmd_defined,
    .pass_through_enable, .addr_mode_hi, .addr_mode_lo, .string_end_match_enable,
    .string_end_reg, .aux_valid, .aux_nonvalid, .hold_acds, .hold_dac, .rfd_allow
  );
  gis_bus_peer i_gis_bus_peer (
    .clk, .rfd_allow, .hold(hold_acds | hold_dac), .dio_in, .eoi, .acds, .stuck
  );

  function automatic logic [7:0] ev(input int p);
    return 8'h01 << p;
  endfunction : ev

  function automatic logic exp_irq(input logic [7:0] s, input logic [7:0] k);
    return |(s & k);
  endfunction : exp_irq

  task automatic report_and_stop;
    if (fail_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  // leading idle cycle keeps back-to-back strobes from two drives in one step
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    cyc(1);
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    cyc(1);
    wr_en = 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    cyc(1);
    addr = a;
    rd_en = 1'b1;
    cyc(1);
    rd_en = 1'b0;
    d = rdata;
  endtask : rd

  task automatic rd_ck(input logic [11:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    check(d, exp);
  endtask : rd_ck

  // one command from the peer; host inspects and releases while it is held
  task automatic pass_case(input logic [5:0] c, input logic [7:0] st, input logic hd);
    logic [7:0] v;
    v = 8'($urandom);
    cls = c;
    fork
      i_gis_bus_peer.put(v, 1'b0);
      begin
        cyc(4);
        check(hold_acds | hold_dac, hd);
        if (hd)
          rd_ck(12'h11B, v);
        rd_ck(12'h113, st);
        aux_valid = ~addr_mode_lo | v[0];
        aux_nonvalid = addr_mode_lo & ~v[0];
        cyc(1);
        {aux_valid, aux_nonvalid} = 2'b00;
      end
    join
    cls = 6'h00;
    cyc(2);
    check({hold_acds, hold_dac}, 2'b00);
  endtask : pass_case

  // bound on the whole run
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    report_and_stop;
  end

  initial
  begin
    {addr, wr_en, rd_en, wdata, string_end_reg, cls, tacs, cacs, sgns, sdys, sids, lacs, tads,
     lads, tpas, lpas, dtas, dcas, dac, rfd, aux_valid, aux_nonvalid, pass_through_enable,
     addr_mode_hi, addr_mode_lo, string_end_match_enable} = '0;
    void'($urandom(53));
    cyc(3);
    srst = 1'b0;
    check({irq, hold_acds, hold_dac, rfd_allow, dio_out}, 12'h1_00);
    rd_ck(12'h113, 8'h00);
    // talker or controller writes start the source, other writes are refused
    for (int i = 0; i < 8; i++)
    begin
      b = 8'($urandom);
      {tacs, cacs} = (i < 4) ? 2'b10 : 2'b01;
      wr(12'h111, b);
      check({src_start, dio_out}, {1'b1, b});
      {tacs, cacs} = 2'b00;
      wr(12'h111, ~b);
      check({src_start, dio_out}, {1'b0, b});
    end
    // data-out follows talker generate, drops on write and on leaving talker
    wr(12'h113, 8'h00);
    {tacs, sgns} = 2'b11;
    cyc(3);
    rd_ck(12'h113, ev(1));
    sgns = 1'b0;
    cyc(2);
    sgns = 1'b1;
    cyc(3);
    wr(12'h111, 8'h3C);
    cyc(2);
    rd_ck(12'h113, 8'h00);
    sgns = 1'b0;
    cyc(2);
    sgns = 1'b1;
    cyc(3);
    {tacs, sgns} = 2'b00;
    cyc(2);
    rd_ck(12'h113, 8'h00);
    // source faults: early accept, write while idle, delay to idle
    tacs = 1'b1;
    {sdys, dac, rfd} = 3'b111;
    cyc(2);
    {sdys, dac, rfd} = 3'b000;
    cyc(2);
    rd_ck(12'h113, ev(2));
    sids = 1'b1;
    wr(12'h111, 8'hC3);
    cyc(2);
    sids = 1'b0;
    rd_ck(12'h113, ev(2));
    sdys = 1'b1;
    cyc(1);
    {sdys, sids} = 2'b01;
    cyc(2);
    sids = 1'b0;
    rd_ck(12'h113, ev(2));
    tacs = 1'b0;
    // mask only steers the request; corner masks first, then random
    for (int i = 0; i < 5; i++)
    begin
      m = (i == 0) ? ev(5) : (i == 1) ? ~ev(5) : 8'($urandom);
      wr(12'h113, m);
      dtas = 1'b1;
      cyc(4);
      check(irq, exp_irq(ev(5), m));
      rd_ck(12'h113, ev(5));
      dtas = 1'b0;
      cyc(3);
      check(irq, 1'b0);
    end
    wr(12'h113, 8'h00);
    dcas = 1'b1;
    cyc(3);
    dcas = 1'b0;
    rd_ck(12'h113, ev(3));
    // an event landing one cycle before, on or one cycle after the read cycle shows up in exactly one read
    for (int k = 0; k < 3; k++)
    begin
      fork
        rd(12'h113, r1);
        begin
          cyc(k);
          dtas = 1'b1;
        end
      join
      cyc(1);
      dtas = 1'b0;
      cyc(3);
      rd(12'h113, r2);
      check(r1 ^ r2, ev(5));
    end
    // listener bytes: end line, then end-of-string match and mismatch
    lacs = 1'b1;
    b = 8'($urandom);
    i_gis_bus_peer.put(b, 1'b1);
    check(rfd_allow, 1'b0);
    rd_ck(12'h111, b);
    check({rfd_allow, dio_out}, {1'b1, 8'hC3});
    rd_ck(12'h113, ev(4) | ev(0));
    string_end_match_enable = 1'b1;
    string_end_reg = 8'($urandom);
    for (int i = 0; i < 2; i++)
    begin
      i_gis_bus_peer.put(string_end_reg ^ 8'(i), 1'b0);
      rd_ck(12'h111, string_end_reg ^ 8'(i));
      rd_ck(12'h113, (i != 0) ? ev(0) : ev(4) | ev(0));
    end
    lacs = 1'b0;
    // command pass-through and the latch for following secondaries
    pass_through_enable = 1'b1;
    tads = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      pass_case(6'h10, ev(7), 1'b1);
      pass_case(6'h08, ev(7), 1'b1);
      pass_case((i == 0) ? 6'h21 : (i == 1) ? 6'h04 : 6'h02, 8'h00, 1'b0);
      pass_case(6'h08, 8'h00, 1'b0);
    end
    pass_case(6'h20, ev(7), 1'b1);
    pass_through_enable = 1'b0;
    cyc(2);
    pass_through_enable = 1'b1;
    pass_case(6'h08, 8'h00, 1'b0);
    tads = 1'b0;
    pass_case(6'h10, 8'h00, 1'b0);
    lads = 1'b1;
    pass_case(6'h10, ev(7), 1'b1);
    lads = 1'b0;
    pass_through_enable = 1'b0;
    pass_case(6'h20, 8'h00, 1'b0);
    // secondary address pass-through only in mode three
    for (int i = 0; i < 3; i++)
    begin
      {addr_mode_hi, addr_mode_lo, tpas, lpas} = (i == 0) ? 4'hE : (i == 1) ? 4'hD : 4'hA;
      pass_case(6'h08, (i < 2) ? ev(6) : 8'h00, i < 2);
    end
    check(stuck, 1'b0);
    report_and_stop;
  end
endmodule : test_gis_out_irq
`default_nettype wire
